// ### rtl/mmsp_memory_map.sv
// Purpose: low memory remap, shadow, write protect and boot rom decode
// Assumes: cycles present a stable address with a one-cycle request pulse
// Notes:   decode is registered, so answers arrive one mclk after the request
`timescale 1ns/100ps
`default_nettype none
module mmsp_memory_map #(
  parameter int SPEEDUP_HOLD = mmsp_pkg::SPEEDUP_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  input  wire logic [15:0] ioAddr,
  input  wire logic [15:0] ioWdata,
  output var  logic [15:0] ioRdata,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [23:0] memAddr,
  input  wire logic        busMemStrobe,
  input  wire logic        busMaster,
  input  wire logic        parityPortEn,
  input  wire logic [3:0]  irqLines,
  input  wire logic        auto_speedup_en,
  output var  logic        memDone,
  output var  logic        dramSel,
  output var  logic        dramWriteEn,
  output var  logic [23:0] dramAddr,
  output var  logic        expBusSel,
  output var  logic [4:0]  chipSel,
  output var  logic        boot_rom_select,
  output var  logic        parityInvert,
  output var  logic        parityCheckEn,
  output var  logic        rowStrobe,
  output var  logic [15:0] timingCfg,
  output var  logic        fastClock
);
  typedef struct packed {
    logic [15:0] timing;
    logic [15:0] split;
    logic [15:0] shadow;
    logic [15:0] bound;
    logic [15:0] rdata;
    logic        done;
    logic        dram;
    logic        dwe;
    logic [23:0] daddr;
    logic        ebus;
    logic [4:0]  cs;
    logic        romSel;
    logic        pinv;
    logic        pchk;
    logic        ras;
    logic [3:0]  irqPrev;
  } mmsp_st_t;
  mmsp_st_t st_r;
  mmsp_st_t st_nxt;

  logic speedUp;
  logic mouseEdge;
  logic [1:0] cutoff, bios_copy_select, vspan, romLay, mouse, splitSz;
  logic       xMem;
  logic [7:0] seg;
  mmsp_pkg::mmsp_dst_t dst;
  logic [23:0] mapped;
  logic        wrBlock;

  // span sizes window
  // true when address lies in the video window at 0C0000H for the span
  function automatic logic in_video(input logic [23:0] a, input logic [1:0] span);
    logic [23:0] lim;
    lim = 24'(mmsp_pkg::KB16 * ({22'h00_0000, span} + 24'h00_0001));
    in_video = (a[23:16] == mmsp_pkg::SEG_C) && (a[15:0] < lim[15:0] || span == 2'h3);
  endfunction : in_video

  // the length of the relocated window for a remap size code
  function automatic logic [23:0] remap_len(input logic [1:0] sz);
    unique case (sz)
      2'h1:    remap_len = mmsp_pkg::KB256;
      2'h2:    remap_len = mmsp_pkg::KB256 + 24'h01_0000;
      2'h3:    remap_len = mmsp_pkg::KB256 + mmsp_pkg::KB128;
      default: remap_len = 24'h00_0000;
    endcase
  endfunction : remap_len

  assign cutoff  = st_r.shadow[mmsp_pkg::CUTOFF_LSB +: 2];
  assign bios_copy_select     = st_r.shadow[mmsp_pkg::SHD_LSB +: 2];
  assign xMem    = st_r.shadow[mmsp_pkg::XMEM_BIT];
  assign vspan   = st_r.shadow[mmsp_pkg::VSPAN_LSB +: 2];
  assign romLay  = st_r.shadow[mmsp_pkg::ROMLAY_LSB +: 2];
  assign mouse   = st_r.shadow[mmsp_pkg::MOUSE_LSB +: 2];
  assign splitSz = st_r.split[mmsp_pkg::SPLITSZ_LSB +: 2];
  assign seg     = memAddr[23:16];

  always_comb
  begin
    unique case (mouse)
      2'h1:    mouseEdge = irqLines[2] & ~st_r.irqPrev[2]; // IRQ12
      2'h2:    mouseEdge = irqLines[1] & ~st_r.irqPrev[1]; // IRQ4
      2'h3:    mouseEdge = irqLines[0] & ~st_r.irqPrev[0]; // IRQ3
      default: mouseEdge = 1'b0;
    endcase
  end

  mmsp_speedup #(
    .HOLD_CYCLES (SPEEDUP_HOLD)
  ) i_mmsp_speedup (
    .mclk    (mclk),
    .nrst    (nrst),
    .trigger (mouseEdge & auto_speedup_en),
    .speedUp (speedUp)
  );

  // address decode; priority: top rom, rom select, shadow, remap, cutoff
  always_comb
  begin
    dst     = mmsp_pkg::DST_DRAM;
    mapped  = memAddr;
    wrBlock = 1'b0;
    if (seg == mmsp_pkg::SEG_FF ||
        (seg == mmsp_pkg::SEG_FE && romLay == mmsp_pkg::ROM_E128))
      dst = mmsp_pkg::DST_ROM;
    else if (seg == mmsp_pkg::SEG_FE)
      dst = mmsp_pkg::DST_BUS;
    else if (seg == mmsp_pkg::SEG_F)
    begin
      if (bios_copy_select != mmsp_pkg::SHD_NONE && !memWrite)
        dst = mmsp_pkg::DST_DRAM;
      else if (bios_copy_select == mmsp_pkg::SHD_NONE)
        dst = mmsp_pkg::DST_ROM; // rom at F for every layout
      if (bios_copy_select != mmsp_pkg::SHD_NONE && memWrite && st_r.shadow[mmsp_pkg::BIOSWP_BIT])
        wrBlock = 1'b1;
    end
    else if (bios_copy_select == mmsp_pkg::SHD_VID && in_video(memAddr, vspan))
    begin
      mapped = {mmsp_pkg::SEG_E, memAddr[15:0]};
      wrBlock = memWrite & st_r.shadow[mmsp_pkg::BIOSWP_BIT];
    end
    else if (romLay == mmsp_pkg::ROM_SHR && bios_copy_select != mmsp_pkg::SHD_VID
             && in_video(memAddr, vspan))
      dst = mmsp_pkg::DST_ROM;
    else if (seg == mmsp_pkg::SEG_E)
    begin
      if (bios_copy_select == mmsp_pkg::SHD_VID && xMem && memAddr >= mmsp_pkg::E_UPPER)
        dst = mmsp_pkg::DST_DRAM;
      else if (bios_copy_select == mmsp_pkg::SHD_VID || romLay == mmsp_pkg::ROM_SHR)
        dst = mmsp_pkg::DST_BUS;
      else if (bios_copy_select == mmsp_pkg::SHD_E128)
      begin
        dst = memWrite ? mmsp_pkg::DST_DRAM : mmsp_pkg::DST_DRAM;
        wrBlock = memWrite & st_r.shadow[mmsp_pkg::BIOSWP_BIT];
      end
      else if (romLay == mmsp_pkg::ROM_E128)
        dst = mmsp_pkg::DST_ROM;
      else
        dst = mmsp_pkg::DST_BUS;
    end
    else if (seg >= mmsp_pkg::SEG_A && seg <= mmsp_pkg::SEG_F)
      dst = mmsp_pkg::DST_BUS;
    // relocated block; an E segment handed to the bus by video copy or shared rom stays there
    // split bit 7 is A24, above the 24-bit space, so bits 6..2 place A23..A19
    if (splitSz != 2'h0 && memAddr >= mmsp_pkg::LOWMEM_TOP &&
        memAddr < 24'(mmsp_pkg::LOWMEM_TOP + remap_len(splitSz)) &&
        !(seg == mmsp_pkg::SEG_E && (bios_copy_select == mmsp_pkg::SHD_VID || romLay == mmsp_pkg::ROM_SHR)) &&
        dst == mmsp_pkg::DST_BUS)
    begin
      dst    = mmsp_pkg::DST_DRAM;
      mapped = {st_r.split[6:2], 19'h0_0000} + 24'(memAddr - mmsp_pkg::LOWMEM_TOP);
    end
    if (memAddr < mmsp_pkg::LOWMEM_TOP &&
        ((cutoff == 2'h1 && memAddr >= mmsp_pkg::KB512) ||
         (cutoff == 2'h2 && memAddr >= mmsp_pkg::KB256) ||
         (cutoff == 2'h3 && memAddr >= mmsp_pkg::KB128)))
      dst = mmsp_pkg::DST_BUS;
    if (memWrite && st_r.shadow[mmsp_pkg::HMWP_BIT] &&
        {1'b0, memAddr[23:17]} > st_r.bound[7:0] && memAddr[23:16] >= 8'h10)
      wrBlock = 1'b1;
    // blocked write bound for dram goes to no target
    if (wrBlock && dst == mmsp_pkg::DST_DRAM)
      dst = mmsp_pkg::DST_DROP;
  end

  // register writes, reads and cycle answers
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.irqPrev = irqLines;
    st_nxt.done = 1'b0;
    // timing takes effect on the next edge
    if (ioWr)
    begin
      unique case (ioAddr)
        mmsp_pkg::ADDR_NONPAGE_TIMING:
          st_nxt.timing = ioWdata & mmsp_pkg::MASK_NONPAGE_TIMING;
        mmsp_pkg::ADDR_SPLIT_START:
          st_nxt.split  = ioWdata & mmsp_pkg::MASK_SPLIT_START;
        mmsp_pkg::ADDR_SHADOW_WP:
          st_nxt.shadow = ioWdata & mmsp_pkg::MASK_SHADOW_WP;
        mmsp_pkg::ADDR_HM_BOUNDARY:
          st_nxt.bound  = ioWdata & mmsp_pkg::MASK_HM_BOUNDARY;
        default: ;
      endcase
    end
    if (ioRd)
    begin
      unique case (ioAddr)
        mmsp_pkg::ADDR_NONPAGE_TIMING: st_nxt.rdata = st_r.timing;
        mmsp_pkg::ADDR_SPLIT_START:    st_nxt.rdata = st_r.split;
        mmsp_pkg::ADDR_SHADOW_WP:      st_nxt.rdata = st_r.shadow;
        mmsp_pkg::ADDR_HM_BOUNDARY:    st_nxt.rdata = st_r.bound;
        default:                       st_nxt.rdata = 16'h0000;
      endcase
    end
    if (memReq)
    begin
      st_nxt.done   = 1'b1;
      st_nxt.dram   = (dst == mmsp_pkg::DST_DRAM);
      st_nxt.dwe    = (dst == mmsp_pkg::DST_DRAM) && memWrite;
      st_nxt.daddr  = mapped;
      st_nxt.ebus   = (dst == mmsp_pkg::DST_BUS);
      st_nxt.romSel = (dst == mmsp_pkg::DST_ROM);
      st_nxt.cs     = (dst == mmsp_pkg::DST_ROM) ? mmsp_pkg::CS_BOOTROM : mmsp_pkg::CS_IDLE;
    end
    st_nxt.pinv = st_r.shadow[mmsp_pkg::PFLIP_BIT];
    st_nxt.pchk = parityPortEn & ~st_r.shadow[mmsp_pkg::POFF_BIT];
    // row strobe follows bus memory strobe while busMaster is high
    st_nxt.ras  = busMaster & busMemStrobe;
  end

  // the one state register, reset to documented defaults
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r        <= '0;
      st_r.timing <= mmsp_pkg::RST_NONPAGE_TIMING;
      st_r.split  <= mmsp_pkg::RST_SPLIT_START;
      st_r.shadow <= mmsp_pkg::RST_SHADOW_WP;
      st_r.bound  <= mmsp_pkg::RST_HM_BOUNDARY;
      st_r.cs     <= mmsp_pkg::CS_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign ioRdata         = st_r.rdata;
  assign memDone         = st_r.done;
  assign dramSel         = st_r.dram;
  assign dramWriteEn     = st_r.dwe;
  assign dramAddr        = st_r.daddr;
  assign expBusSel       = st_r.ebus;
  assign chipSel         = st_r.cs;
  assign boot_rom_select = st_r.romSel;
  assign parityInvert    = st_r.pinv;
  assign parityCheckEn   = st_r.pchk;
  assign rowStrobe       = st_r.ras;
  assign timingCfg       = st_r.timing;
  assign fastClock       = speedUp;

  property p_top_rom;
    @(posedge mclk) disable iff (!nrst)
      memReq && memAddr[23:16] == 8'hFF |=> boot_rom_select && !dramSel;
  endproperty
  a_top_rom: assert property (p_top_rom) else $error("top rom went to dram");
  property p_cs_code;
    @(posedge mclk) disable iff (!nrst)
      boot_rom_select |-> chipSel == 5'h00;
  endproperty
  a_cs_code: assert property (p_cs_code) else $error("rom select code wrong");
  property p_timing_now;
    @(posedge mclk) disable iff (!nrst)
      ioWr && ioAddr == 16'h4072 |=> timingCfg == ($past(ioWdata) & 16'h7F7F);
  endproperty
  a_timing_now: assert property (p_timing_now) else $error("timing not immediate");
  property p_par_off;
    @(posedge mclk) disable iff (!nrst)
      st_r.shadow[10] |=> !parityCheckEn;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity not disabled");
  property p_par_inv;
    @(posedge mclk) disable iff (!nrst)
      ##1 parityInvert == $past(st_r.shadow[11]);
  endproperty
  a_par_inv: assert property (p_par_inv) else $error("parity flip wrong");
  property p_blocked;
    @(posedge mclk) disable iff (!nrst)
      memReq && memWrite && wrBlock |=> memDone && !dramWriteEn;
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked write reached dram");
  property p_row;
    @(posedge mclk) disable iff (!nrst)
      busMaster && busMemStrobe |=> rowStrobe;
  endproperty
  a_row: assert property (p_row) else $error("row strobe late");
  property p_ebus;
    @(posedge mclk) disable iff (!nrst)
      memReq && memAddr[23:16] == 8'h0E && st_r.shadow[9:8] == 2'h3 && !st_r.shadow[7]
      |=> expBusSel && !boot_rom_select;
  endproperty
  a_ebus: assert property (p_ebus) else $error("E segment not on bus");
  property p_vid_copy;
    @(posedge mclk) disable iff (!nrst)
      memReq && st_r.shadow[9:8] == 2'h3 && memAddr[23:16] == 8'h0C &&
      memAddr[15:14] <= st_r.shadow[5:4] |=> dramAddr[23:16] == 8'h0E;
  endproperty
  a_vid_copy: assert property (p_vid_copy) else $error("video copy not in E segment");
  property p_hm_guard;
    @(posedge mclk) disable iff (!nrst)
      memReq && memWrite && st_r.shadow[13] && memAddr[23:20] != 4'h0 &&
      {1'b0, memAddr[23:17]} > st_r.bound[7:0] |=> !dramWriteEn;
  endproperty
  a_hm_guard: assert property (p_hm_guard) else $error("guarded write reached dram");
endmodule : mmsp_memory_map
`default_nettype wire

// ### rtl/mmsp_speedup.sv
// Purpose: one second speed-up hold after pointer activity
// Assumes: activity is a one-cycle pulse synchronous to mclk
// Notes:   the hold length is a parameter so simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
module mmsp_speedup #(
  parameter int HOLD_CYCLES = mmsp_pkg::SPEEDUP_CYCLES
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic trigger,
  output var  logic speedUp
);
  typedef struct packed {
    logic [26:0] count;
    logic        busy;
  } mmsp_su_t;
  mmsp_su_t st_r;
  mmsp_su_t st_nxt;

  // retrigger restarts the full hold
  always_comb
  begin
    st_nxt = st_r;
    if (trigger)
    begin
      st_nxt.count = 27'(HOLD_CYCLES - 1);
      st_nxt.busy  = 1'b1;
    end
    else if (st_r.busy)
    begin
      if (st_r.count == 27'h000_0000)
        st_nxt.busy = 1'b0;
      else
        st_nxt.count = st_r.count - 27'h000_0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign speedUp = st_r.busy;

  property p_hold_start;
    @(posedge mclk) disable iff (!nrst)
      trigger |=> speedUp;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("speed-up did not start");
endmodule : mmsp_speedup
`default_nettype wire

// ### shared/mmsp_pkg.sv
// Purpose: constants for the memory map, shadow and write protect block
// Assumes: 16-bit register port, 24-bit physical memory address
// Notes:   all offsets, field positions, reset values and timing counts live here
package mmsp_pkg;
  // register port addresses
  localparam logic [15:0] ADDR_NONPAGE_TIMING = 16'h4072;
  localparam logic [15:0] ADDR_SPLIT_START    = 16'h5872;
  localparam logic [15:0] ADDR_SHADOW_WP      = 16'h6072;
  localparam logic [15:0] ADDR_HM_BOUNDARY    = 16'hC072;
  // reset values
  localparam logic [15:0] RST_NONPAGE_TIMING = 16'h0000;
  localparam logic [15:0] RST_SPLIT_START    = 16'h0000;
  localparam logic [15:0] RST_SHADOW_WP      = 16'h0004; // boot_rom_layout 01
  localparam logic [15:0] RST_HM_BOUNDARY    = 16'h0000;
  // writable bit masks (unused bits are ignored and read zero)
  localparam logic [15:0] MASK_NONPAGE_TIMING = 16'h7F7F;
  localparam logic [15:0] MASK_SPLIT_START    = 16'hFFFC;
  localparam logic [15:0] MASK_SHADOW_WP      = 16'hFFBF;
  localparam logic [15:0] MASK_HM_BOUNDARY    = 16'h00FF;
  // shadow register field positions
  localparam int CUTOFF_LSB  = 14;
  localparam int HMWP_BIT    = 13;
  localparam int BIOSWP_BIT  = 12;
  localparam int PFLIP_BIT   = 11;
  localparam int POFF_BIT    = 10;
  localparam int SHD_LSB     = 8;
  localparam int XMEM_BIT    = 7;
  localparam int VSPAN_LSB   = 4;
  localparam int ROMLAY_LSB  = 2;
  localparam int MOUSE_LSB   = 0;
  // split register fields
  localparam int SPLITSZ_LSB = 8;
  localparam int SPLITA_LSB  = 2;
  // memory segment numbers (address bits 23..16)
  localparam logic [7:0] SEG_A  = 8'h0A;
  localparam logic [7:0] SEG_C  = 8'h0C;
  localparam logic [7:0] SEG_D  = 8'h0D;
  localparam logic [7:0] SEG_E  = 8'h0E;
  localparam logic [7:0] SEG_F  = 8'h0F;
  localparam logic [7:0] SEG_FE = 8'hFE;
  localparam logic [7:0] SEG_FF = 8'hFF;
  localparam logic [23:0] LOWMEM_TOP = 24'h0A_0000; // 640 KB
  localparam logic [23:0] KB128      = 24'h02_0000;
  localparam logic [23:0] KB256      = 24'h04_0000;
  localparam logic [23:0] KB512      = 24'h08_0000;
  localparam logic [23:0] KB16       = 24'h00_4000;
  localparam logic [23:0] E_UPPER    = 24'h0E_8000;
  // chip select code of the boot rom, and idle code
  localparam logic [4:0] CS_BOOTROM = 5'h00;
  localparam logic [4:0] CS_IDLE    = 5'h1F;
  // mouse speed-up hold, one second at mclk
  localparam real    CLK_MHZ        = 10.0;
  localparam real    SPEEDUP_SEC    = 1.0;
  localparam int     SPEEDUP_CYCLES = int'(SPEEDUP_SEC * CLK_MHZ * 1.0e6);
  // field encodings
  localparam logic [1:0] SHD_NONE = 2'h0;
  localparam logic [1:0] SHD_F64  = 2'h1;
  localparam logic [1:0] SHD_E128 = 2'h2;
  localparam logic [1:0] SHD_VID  = 2'h3;
  localparam logic [1:0] ROM_E128 = 2'h0;
  localparam logic [1:0] ROM_F64  = 2'h1;
  localparam logic [1:0] ROM_SHR  = 2'h2;
  // memory cycle destinations
  typedef enum logic [3:0] {
    DST_DRAM = 4'b0001,
    DST_ROM  = 4'b0010,
    DST_BUS  = 4'b0100,
    DST_DROP = 4'b1000
  } mmsp_dst_t;
endpackage : mmsp_pkg

// ### testbench/memory_map_shadow_protect_tb_top.sv
// Purpose: self-checking bench for the memory map, shadow and protect block
// Assumes: answers are registered on the taking edge and checked 1 ns after it
// Notes:   speed-up hold shortened to 20 cycles to keep the run short
`timescale 1ns/100ps
`default_nettype none
module memory_map_shadow_protect_tb_top;
  localparam logic [15:0] TM = mmsp_pkg::ADDR_NONPAGE_TIMING;
  localparam logic [15:0] SP = mmsp_pkg::ADDR_SPLIT_START;
  localparam logic [15:0] SH = mmsp_pkg::ADDR_SHADOW_WP;
  localparam logic [15:0] HB = mmsp_pkg::ADDR_HM_BOUNDARY;
  // route codes {dramSel, dramWriteEn, expBusSel, boot_rom_select}
  localparam logic [3:0] D = 4'h8;
  localparam logic [3:0] W = 4'hC;
  localparam logic [3:0] B = 4'h2;
  localparam logic [3:0] R = 4'h1;
  localparam logic [3:0] X = 4'h0;
  logic        mclk, nrst, ioWr, ioRd, memReq, memWrite, busMemStrobe, busMaster;
  logic        parityPortEn, auto_speedup_en, memDone, dramSel, dramWriteEn, expBusSel;
  logic        boot_rom_select, parityInvert, parityCheckEn, rowStrobe, fastClock;
  logic [15:0] ioAddr, ioWdata, ioRdata, timingCfg;
  logic [23:0] memAddr, dramAddr;
  logic [4:0]  chipSel;
  logic [3:0]  irqLines;
  logic [23:0] last [3];
  int          errors, checked, cyc, i;

  mmsp_memory_map #(.SPEEDUP_HOLD(20)) i_mmsp_memory_map (.mclk, .nrst, .ioWr, .ioRd,
    .ioAddr, .ioWdata, .ioRdata, .memReq, .memWrite, .memAddr, .busMemStrobe,
    .busMaster, .parityPortEn, .irqLines, .auto_speedup_en, .memDone, .dramSel,
    .dramWriteEn, .dramAddr, .expBusSel, .chipSel, .boot_rom_select, .parityInvert,
    .parityCheckEn, .rowStrobe, .timingCfg, .fastClock);
  mmsp_cycle_src i_src (.mclk, .memReq, .memWrite, .memAddr, .busMemStrobe, .busMaster);

  // 100 ns clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic conclude();
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (e !== g)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // register port write; released lines show their inverse
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    ioWr    <= 1'b1;
    ioAddr  <= a;
    ioWdata <= d;
    @(posedge mclk);
    ioWr    <= 1'b0;
    ioAddr  <= ~a;
    ioWdata <= ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge mclk);
    ioRd   <= 1'b1;
    ioAddr <= a;
    @(posedge mclk);
    ioRd   <= 1'b0;
    ioAddr <= ~a;
    #1;
    chk("ioRdata", {8'h0, e}, {8'h0, ioRdata});
  endtask : rd

  // memory cycle, then route, completion and chip select
  task automatic mc(input logic [23:0] a, input logic w, input logic [3:0] e);
    i_src.cycle(a, w);
    #1;
    chk("memDone", 24'h1, {23'h0, memDone});
    chk("route", {20'h0, e}, {20'h0, dramSel, dramWriteEn, expBusSel, boot_rom_select});
    if (e[0])
      chk("chipSel", {19'h0, mmsp_pkg::CS_BOOTROM}, {19'h0, chipSel});
    else
      chk("chipSel", {19'h0, mmsp_pkg::CS_IDLE}, {19'h0, chipSel});
  endtask : mc

  task automatic cyc1(input logic [23:0] n, input logic v);
    repeat (n) @(posedge mclk);
    #1;
    chk("level", {23'h0, v}, {23'h0, fastClock});
  endtask : cyc1

  task automatic pulse(input int b);
    @(posedge mclk);
    irqLines[b] <= 1'b1;
    @(posedge mclk);
    irqLines[b] <= 1'b0;
  endtask : pulse

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      errors++;
      conclude();
    end
  end

  initial
  begin
    {nrst, ioWr, ioRd, auto_speedup_en, irqLines} = '0;
    {ioAddr, ioWdata} = '0;
    parityPortEn = 1'b1;
    last = '{24'h0d_ffff, 24'h0e_ffff, 24'h0e_ffff};
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    // reset values, masks of unused bits, unmapped port
    rd(TM, 16'h0000);
    rd(SP, 16'h0000);
    rd(SH, 16'h0004);
    rd(HB, 16'h0000);
    wr(TM, 16'hffff);
    rd(TM, 16'h7f7f);
    wr(SP, 16'hffff);
    rd(SP, 16'hfffc);
    wr(HB, 16'hffff);
    rd(HB, 16'h00ff);
    rd(16'h0072, 16'h0000);
    wr(TM, 16'h3560);
    #1;
    chk("timingCfg", 24'h3560, {8'h0, timingCfg});
    // boot rom layouts 01 then 00
    wr(SP, 16'h0000);
    wr(SH, 16'h0004);
    mc(24'hff_0000, 1'b0, R);
    mc(24'h0f_0000, 1'b0, R);
    mc(24'hfe_0000, 1'b0, B);
    wr(SH, 16'h0000);
    mc(24'h0e_0000, 1'b0, R);
    mc(24'hfe_ffff, 1'b0, R);
    // cutoff codes 01, 10, 11
    for (i = 0; i < 3; i++)
    begin
      wr(SH, 16'h0004 | (16'(i + 1) << 14));
      mc((24'h08_0000 >> i) - 24'h1, 1'b0, D);
      mc(24'h08_0000 >> i, 1'b0, B);
    end
    // remap sizes, destination 400000, low two bits written but ignored
    wr(SH, 16'h0004);
    for (i = 1; i < 4; i++)
    begin
      wr(SP, (16'(i) << 8) | 16'h0023);
      mc(24'h0a_0000, 1'b0, D);
      chk("dramAddr", 24'h40_0000, dramAddr);
      mc(last[i-1], 1'b0, D);
      chk("dramAddr", last[i-1] + 24'h36_0000, dramAddr);
    end
    wr(SP, 16'h0120);
    mc(24'h0e_0000, 1'b0, B);
    // parity levels are registered from the shadow register, one edge later
    wr(SH, 16'h0804);
    @(posedge mclk);
    #1;
    chk("parityInvert", 24'h1, {23'h0, parityInvert});
    wr(SH, 16'h0404);
    @(posedge mclk);
    #1;
    chk("parityCheckEn", 24'h0, {23'h0, parityCheckEn});
    wr(SH, 16'h0004);
    @(posedge mclk);
    #1;
    chk("parityCheckEn", 24'h1, {23'h0, parityCheckEn});
    chk("parityInvert", 24'h0, {23'h0, parityInvert});
    // with the override clear, the port enable alone governs checking
    @(posedge mclk);
    parityPortEn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("parityCheckEn", 24'h0, {23'h0, parityCheckEn});
    @(posedge mclk);
    parityPortEn <= 1'b1;
    // upper guard, boundary upper byte ignored
    wr(HB, 16'hff08);
    wr(SH, 16'h2004);
    mc(24'h20_0000, 1'b1, X);
    mc(24'h10_0000, 1'b1, W);
    wr(SH, 16'h0004);
    mc(24'h20_0000, 1'b1, W);
    // split first, then shadow and its guard
    wr(SP, 16'h0220);
    wr(SH, 16'h0104);
    mc(24'h0f_0000, 1'b0, D);
    mc(24'h0f_0000, 1'b1, W);
    mc(24'hff_0000, 1'b0, R);
    wr(SH, 16'h1104);
    mc(24'h0f_ffff, 1'b1, X);
    wr(SP, 16'h0120);
    wr(SH, 16'h0204);
    mc(24'h0e_0000, 1'b0, D);
    // video copy window at C segment for every span
    for (i = 0; i < 4; i++)
    begin
      wr(SH, 16'h0304 | (16'(i) << 4));
      mc(24'h0c_0000 + (24'h00_4000 * (i + 1)) - 24'h1, 1'b0, D);
      chk("dramAddr", 24'h0e_0000 + (24'h00_4000 * (i + 1)) - 24'h1, dramAddr);
    end
    wr(SH, 16'h0314);
    mc(24'h0c_8000, 1'b0, D);
    chk("dramAddr", 24'h42_8000, dramAddr);
    mc(24'h0e_0000, 1'b0, B);
    mc(24'h0e_8000, 1'b0, B);
    wr(SH, 16'h0394);
    mc(24'h0e_8000, 1'b1, W);
    // shared rom layout
    wr(SP, 16'h0000);
    wr(SH, 16'h0008);
    mc(24'h0c_3fff, 1'b0, R);
    mc(24'h0c_4000, 1'b0, B);
    mc(24'h0e_0000, 1'b0, B);
    // pointer wake for each irq selection, stray line and disabled cases
    pulse(2);
    cyc1(3, 1'b0);
    @(posedge mclk);
    auto_speedup_en <= 1'b1;
    for (i = 1; i < 4; i++)
    begin
      wr(SH, 16'h0004 | 16'(i));
      pulse((4 - i) % 3);
      cyc1(3, 1'b0);
      pulse(3 - i);
      cyc1(3, 1'b1);
      cyc1(30, 1'b0);
    end
    // bus master row strobe follows the bus strobe level
    i_src.strobe(1'b1, 1'b1);
    repeat (2) @(posedge mclk);
    #1;
    chk("rowStrobe", 24'h1, {23'h0, rowStrobe});
    i_src.strobe(1'b1, 1'b0);
    repeat (2) @(posedge mclk);
    #1;
    chk("rowStrobe", 24'h0, {23'h0, rowStrobe});
    conclude();
  end
endmodule : memory_map_shadow_protect_tb_top
`default_nettype wire

// ### testbench/mmsp_cycle_src.sv
// Purpose: processor or bus master that issues memory cycles to the map block
// Assumes: one request pulse per cycle, address valid only while requesting
// Notes:   a released address shows its inverse, so a stale value never decodes
`timescale 1ns/100ps
`default_nettype none
module mmsp_cycle_src (
  input  wire logic        mclk,
  output var  logic        memReq,
  output var  logic        memWrite,
  output var  logic [23:0] memAddr,
  output var  logic        busMemStrobe,
  output var  logic        busMaster
);
  // idle bus at time zero
  initial
  begin
    memReq       = 1'b0;
    memWrite     = 1'b0;
    memAddr      = 24'h0;
    busMemStrobe = 1'b0;
    busMaster    = 1'b0;
  end
  // one cycle: request rises after an edge, is taken on the next, then drops
  task automatic cycle(input logic [23:0] a, input logic w);
    @(posedge mclk);
    memReq   <= 1'b1;
    memWrite <= w;
    memAddr  <= a;
    @(posedge mclk);
    memReq   <= 1'b0;
    memWrite <= ~w;
    memAddr  <= ~a;
  endtask : cycle
  // bus master strobe levels, held until changed
  task automatic strobe(input logic m, input logic s);
    @(posedge mclk);
    busMaster    <= m;
    busMemStrobe <= s;
  endtask : strobe
endmodule : mmsp_cycle_src
`default_nettype wire
